// ### verilog/abs_answerback.sv
// answer-back sequencer with apb registers, line serialiser and kbd buffer
// Notes on behaviour
// - characters the device sends itself never fire the answer-back.
// - each local transmit cycle raises the block, released in its last bit.
// - a remote character equal to the call code starts the sequence.
// - message splits into one, two or three segments; a trigger sends one.
// - single uses rows 0..20, triple uses three segments of seven rows.
// - double uses segments of 10 and 11 rows, alternating per trigger.
// - a suppressed row takes a full cycle with the line held marking.
// - a suppressed last row leaves the block set after the sequence.
// - the next received character clears that left-over block.
// - print-inhibit mode kills function decode and all printing.
// - a lamp output shows print-inhibit mode.
// - remote on enters print-inhibit mode; remote off leaves it only while the local switch is off.
// - one row per character cycle is sent as a start-stop character.
// - the first row of every sequence is always suppressed.
// - local request and external trip also start the sequence.
`timescale 1ns/10ps
`include "abs_consts.svh"
module abs_answerback #(
   parameter int BIT_CYCLES = `ABS_BIT_US * `ABS_CLK_MHZ
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   // received characters from the selector
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_char_in,
   // triggers and print-inhibit commands
   input  wire logic        here_is_in,
   input  wire logic        ext_trip_in,
   input  wire logic        np_on_in,
   input  wire logic        np_off_in,
   // keyboard characters
   input  wire logic        kb_valid_in,
   input  wire logic [7:0]  kb_char_in,
   output logic             kb_ready_out,
   // line and printer
   output logic             line_out,
   output logic             print_valid_out,
   output logic [7:0]       print_char_out,
   output logic             np_lamp_out,
   output logic             ab_busy_out
);
   // end row of the segment that begins at start
   function automatic logic [4:0] seg_end(input logic [1:0] mode,
                                          input logic [4:0] start);
      case (mode)
         abs_pkg::ABS_DOUBLE: seg_end = (start == 5'h00) ?
                                 `ABS_DBL_A_END : `ABS_LAST_ROW;
         abs_pkg::ABS_TRIPLE: seg_end = start + `ABS_TRI_LEN;
         default:             seg_end = `ABS_LAST_ROW;
      endcase
   endfunction

   // first row of the next segment; a pointer left over from another
   // mode falls back to row 0, so every segment keeps its fixed size
   function automatic logic [4:0] seg_first(input logic [1:0] mode,
                                            input logic [4:0] start);
      case (mode)
         abs_pkg::ABS_DOUBLE:
            seg_first = (start == `ABS_DBL_A_END + 5'h01) ? start : 5'h00;
         abs_pkg::ABS_TRIPLE:
            seg_first = (start == `ABS_TRI_LEN + 5'h01 ||
                         start == `ABS_TRI_LEN + `ABS_TRI_LEN + 5'h02) ?
                        start : 5'h00;
         default:
            seg_first = 5'h00;
      endcase
   endfunction

   abs_pkg::abs_row_type   drum_r [0:`ABS_ROWS-1];
   abs_pkg::abs_state_type state_r;
   logic [1:0]  mode_r;
   logic        np_sw_r, np_rem_r, block_r, last_sup_r, trip_d_r;
   logic [7:0]  call_r;
   logic [4:0]  maddr_r, row_r, start_r, end_r;
   logic        pready_r, pslverr_r;
   logic [31:0] prdata_r;
   logic        tx_busy_r, tx_ab_r;
   logic [10:0] tx_sh_r;
   logic [3:0]  tx_bit_r;
   logic [31:0] div_r;
   logic [7:0]  fifo_r [0:1];
   logic        wr_ptr_r, rd_ptr_r, kb_ready_r;
   logic [1:0]  cnt_r;
   logic        pv_r, lamp_r;
   logic [7:0]  pc_r;

   // apb decode
   wire         setup    = psel_in & ~penable_in;
   wire         acc_done = psel_in & penable_in & pready_r;
   wire         wr_en    = acc_done & pwrite_in;
   wire         hit_ctrl = paddr_in == `ABS_CTRL_OFS;
   wire         hit_stat = paddr_in == `ABS_STAT_OFS;
   wire         hit_madr = paddr_in == `ABS_MADDR_OFS;
   wire         hit_mdat = paddr_in == `ABS_MDATA_OFS;
   wire         mapped   = hit_ctrl | hit_stat | hit_madr | hit_mdat;
   wire         maddr_ok = maddr_r < 5'(`ABS_ROWS);
   wire [31:0]  ctrl_rd  = {16'h0000, call_r, 5'h00, np_sw_r, mode_r};
   wire [31:0]  stat_rd  = {11'h000, row_r, 3'h0, start_r, 4'h0,
                             ab_busy_out, np_lamp_out, block_r,
                             state_r != abs_pkg::ABS_IDLE};
   wire [31:0]  mdat_rd  = maddr_ok ? {23'h0, drum_r[maddr_r]} : 32'h0;
   wire [31:0]  rd_mux   = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd :
                           hit_madr ? {27'h0, maddr_r} :
                           hit_mdat ? mdat_rd : 32'h0;

   // apb handshake: one wait cycle, unmapped gives an error
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= psel_in & penable_in & ~pready_r;
         pslverr_r <= psel_in & penable_in & ~pready_r & ~mapped;
         if (setup)
            prdata_r <= pwrite_in ? 32'h0 : rd_mux;
      end
   end

   // control registers and message address
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode_r  <= 2'(`ABS_CTRL_RST);
         np_sw_r <= 1'b0;
         call_r  <= `ABS_CALL_RST;
         maddr_r <= 5'h00;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            mode_r  <= pwdata_in[`ABS_CTRL_MODE_HI:`ABS_CTRL_MODE_LO];
            np_sw_r <= pwdata_in[`ABS_CTRL_NP];
            call_r  <= pwdata_in[`ABS_CTRL_CALL_HI:`ABS_CTRL_CALL_LO];
         end
         if (hit_madr)
            maddr_r <= pwdata_in[4:0];
      end
   end

   // message rows, written one per access; software fills each segment
   always_ff @(posedge clk_in) begin
      if (wr_en & hit_mdat & maddr_ok)
         drum_r[maddr_r] <= pwdata_in[8:0];
   end

   // print-inhibit mode from the local switch or remote commands
   wire np_active = np_sw_r | np_rem_r;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         np_rem_r <= 1'b0;
         lamp_r   <= 1'b0;
      end else begin
         if (np_on_in)
            np_rem_r <= 1'b1;
         else if (np_off_in)
            np_rem_r <= 1'b0;
         lamp_r <= np_active;
      end
   end

   // bit-rate divider and serialiser state
   wire bit_tick = tx_busy_r & (div_r == 32'(BIT_CYCLES - 1));
   wire tx_done  = bit_tick & (tx_bit_r == `ABS_LAST_BIT);
   // own transmit holds the block until the final stop bit
   wire own_blk  = tx_busy_r & (tx_bit_r != `ABS_LAST_BIT);

   // trigger sources
   wire idle     = state_r == abs_pkg::ABS_IDLE;
   wire rx_call  = rx_valid_in & ~own_blk & ~np_active &
                   (rx_char_in == call_r);
   wire trip_up  = ext_trip_in & ~trip_d_r;
   wire any_trig = rx_call | here_is_in | trip_up;
   wire start_ok = idle & ~block_r & ~tx_busy_r & any_trig;
   wire ab_load  = state_r == abs_pkg::ABS_LOAD;
   wire kb_load  = idle & ~start_ok & ~tx_busy_r & (cnt_r != 2'h0);
   abs_pkg::abs_row_type row_q;
   assign row_q = drum_r[row_r];
   wire row_sup  = row_q.sup | (row_r == start_r);
   wire at_end   = row_r == end_r;
   wire [4:0] first_row = seg_first(mode_r, start_r);

   // sequencer: one row per character cycle through the segment
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r    <= abs_pkg::ABS_IDLE;
         row_r      <= 5'h00;
         start_r    <= 5'h00;
         end_r      <= 5'h00;
         block_r    <= 1'b0;
         last_sup_r <= 1'b0;
         trip_d_r   <= 1'b0;
      end else begin
         trip_d_r <= ext_trip_in;
         case (state_r)
            abs_pkg::ABS_IDLE: begin
               if (start_ok) begin
                  row_r   <= first_row;
                  start_r <= first_row;
                  end_r   <= seg_end(mode_r, first_row);
                  state_r <= abs_pkg::ABS_LOAD;
               end else if (rx_valid_in) begin
                  block_r <= 1'b0;
               end
            end
            abs_pkg::ABS_LOAD: begin
               last_sup_r <= row_sup;
               state_r    <= abs_pkg::ABS_WAIT;
            end
            abs_pkg::ABS_WAIT: begin
               if (tx_done) begin
                  if (at_end) begin
                     block_r <= last_sup_r;
                     start_r <= (mode_r == abs_pkg::ABS_SINGLE ||
                                 end_r >= `ABS_LAST_ROW) ?
                                5'h00 : end_r + 5'h01;
                     state_r <= abs_pkg::ABS_IDLE;
                  end else begin
                     row_r   <= row_r + 5'h01;
                     state_r <= abs_pkg::ABS_LOAD;
                  end
               end
            end
            default: state_r <= abs_pkg::ABS_IDLE;
         endcase
      end
   end

   // start-stop serialiser: start, eight data lsb first, two stops
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_busy_r <= 1'b0;
         tx_ab_r   <= 1'b0;
         tx_sh_r   <= 11'h7ff;
         tx_bit_r  <= 4'h0;
         div_r     <= 32'h0;
      end else if (ab_load | kb_load) begin
         tx_busy_r <= 1'b1;
         tx_ab_r   <= ab_load;
         div_r     <= 32'h0;
         tx_bit_r  <= 4'h0;
         if (ab_load & row_sup)
            tx_sh_r <= 11'h7ff;
         else if (ab_load)
            tx_sh_r <= {2'b11, row_q.code, 1'b0};
         else
            tx_sh_r <= {2'b11, fifo_r[rd_ptr_r], 1'b0};
      end else if (tx_busy_r) begin
         div_r <= bit_tick ? 32'h0 : div_r + 32'h1;
         if (bit_tick) begin
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_done)
               tx_busy_r <= 1'b0;
         end
      end
   end

   // two-entry keyboard buffer feeding the serialiser
   wire       kb_push = kb_valid_in & kb_ready_r;
   wire [1:0] cnt_nxt = cnt_r + {1'b0, kb_push} - {1'b0, kb_load};
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_r   <= 1'b0;
         rd_ptr_r   <= 1'b0;
         cnt_r      <= 2'h0;
         kb_ready_r <= 1'b0;
      end else begin
         if (kb_push) begin
            fifo_r[wr_ptr_r] <= kb_char_in;
            wr_ptr_r         <= ~wr_ptr_r;
         end
         if (kb_load)
            rd_ptr_r <= ~rd_ptr_r;
         cnt_r      <= cnt_nxt;
         kb_ready_r <= cnt_nxt != 2'h2;
      end
   end

   // printer strobe: nothing prints while print-inhibit is on
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pv_r <= 1'b0;
         pc_r <= 8'h00;
      end else begin
         pv_r <= rx_valid_in & ~np_active;
         if (rx_valid_in)
            pc_r <= rx_char_in;
      end
   end

   // outputs straight from flip-flops
   assign pready_out      = pready_r;
   assign prdata_out      = prdata_r;
   assign pslverr_out     = pslverr_r;
   assign line_out        = tx_sh_r[0];
   assign kb_ready_out    = kb_ready_r;
   assign print_valid_out = pv_r;
   assign print_char_out  = pc_r;
   assign np_lamp_out     = lamp_r;
   assign ab_busy_out     = tx_busy_r;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_own_no_trig: assert property (own_blk & idle & ~block_r |=>
      state_r != abs_pkg::ABS_LOAD || $past(here_is_in | trip_up))
      else $error("own character started the sequence");
   a_blk_release: assert property (tx_done |-> ~own_blk)
      else $error("block still set in last bit");
   a_call_start: assert property (rx_call & idle & ~block_r & ~tx_busy_r
      |=> state_r == abs_pkg::ABS_LOAD && row_r == $past(first_row))
      else $error("call character did not start");
   a_seg_single: assert property (start_ok & mode_r == 2'h0 |=>
      end_r == 5'h14 && row_r == 5'h00)
      else $error("single segment bounds wrong");
   a_seg_double: assert property (start_ok & mode_r == 2'h1 |=>
      end_r == ((row_r == 5'h00) ? 5'h09 : 5'h14))
      else $error("double segment bounds wrong");
   a_seg_triple: assert property (start_ok & mode_r == 2'h2 |=>
      end_r == row_r + 5'h06)
      else $error("triple segment length wrong");
   a_sup_mark: assert property (ab_load & row_sup |=>
      tx_sh_r == 11'h7ff)
      else $error("suppressed row not held marking");
   a_first_sup: assert property (ab_load & (row_r == start_r) |=>
      line_out)
      else $error("first row not suppressed");
   a_blk_left: assert property (state_r == abs_pkg::ABS_WAIT & tx_done &
      at_end |=> block_r == $past(last_sup_r))
      else $error("left-over block wrong");
   a_blk_clear: assert property (idle & block_r & rx_valid_in |=>
      ~block_r)
      else $error("received char did not clear block");
   a_np_print: assert property (np_active & rx_valid_in |=> ~pv_r)
      else $error("printed in print-inhibit mode");
   a_np_lamp: assert property (np_on_in |=> ##1 np_lamp_out)
      else $error("lamp did not light");
   a_no_queue: assert property (~idle & any_trig |=> ~start_ok ||
      $past(state_r) != abs_pkg::ABS_LOAD)
      else $error("trigger taken while busy");
   c_call: cover property (rx_call ##1 state_r == abs_pkg::ABS_LOAD);
   c_double: cover property (start_ok & mode_r == 2'h1 & start_r != 0);
   c_blocked: cover property (block_r & any_trig & idle);
   c_kb_full: cover property (cnt_r == 2'h2 & kb_valid_in);
endmodule

// ### verilog/abs_consts.svh
// constants for the answer-back sequencer
`ifndef ABS_CONSTS_SVH
`define ABS_CONSTS_SVH
// apb byte offsets
`define ABS_CTRL_OFS    8'h00
`define ABS_STAT_OFS    8'h04
`define ABS_MADDR_OFS   8'h08
`define ABS_MDATA_OFS   8'h0c
// control field positions
`define ABS_CTRL_MODE_LO 0
`define ABS_CTRL_MODE_HI 1
`define ABS_CTRL_NP      2
`define ABS_CTRL_CALL_LO 8
`define ABS_CTRL_CALL_HI 15
// reset values
`define ABS_CTRL_RST    32'h0000_0000
`define ABS_CALL_RST    8'h05
// drum geometry
`define ABS_ROWS        21
`define ABS_LAST_ROW    5'h14
`define ABS_DBL_A_END   5'h09
`define ABS_TRI_LEN     5'h06
// serial timing: bit time in microseconds, clock in mhz
`define ABS_BIT_US      9091
`define ABS_CLK_MHZ     50
`define ABS_CHAR_BITS   11
`define ABS_LAST_BIT    4'ha
`endif

// ### verilog/abs_pkg.sv
// types shared by the answer-back sequencer
package abs_pkg;
   typedef enum logic [1:0] {
      ABS_SINGLE,
      ABS_DOUBLE,
      ABS_TRIPLE,
      ABS_RSVD
   } abs_mode_type;
   typedef enum {
      ABS_IDLE,
      ABS_LOAD,
      ABS_WAIT
   } abs_state_type;
   typedef struct packed {
      logic       sup;
      logic [7:0] code;
   } abs_row_type;
endpackage

// ### tb/abs_far_station.sv
// distant station model: decodes line frames, feeds the receive path
`timescale 1ns/10ps
module abs_far_station #(
   parameter int BIT_CYCLES = 8
) (
   // clock and reset
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   // line from the device and echo enable
   input  wire logic  line_in,
   input  wire logic  echo_in,
   // characters into the receive path
   output logic       rx_valid_out,
   output logic [7:0] rx_char_out
);
   logic [7:0] got[$];
   logic [7:0] sh;
   // one received character, data scrambled once released
   task automatic send(input logic [7:0] c);
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_char_out  <= c;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_char_out  <= ~c;
   endtask
   initial begin
      rx_valid_out = 1'b0;
      rx_char_out  = 8'h00;
   end
   // sample each data bit mid-bit, lsb first; echo lands in the last data bit
   always begin
      @(posedge clk_in);
      if (!rst_in && line_in === 1'b0) begin
         repeat (BIT_CYCLES / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_in);
            sh[i] = line_in;
         end
         got.push_back(sh);
         if (echo_in) send(sh);
         repeat (BIT_CYCLES) @(posedge clk_in);
      end
   end
endmodule

// ### tb/test_answerback_sequencer.sv
// self-checking bench for the answer-back sequencer
`timescale 1ns/10ps
`include "abs_consts.svh"
module test_answerback_sequencer;
   localparam int BC = 8;
   logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, kb_char, print_char, plast;
   logic [31:0] pwdata, prdata, rdv;
   logic        rx_valid, here_is, ext_trip, np_on, np_off, erv;
   logic [7:0]  rx_char;
   logic        kb_valid, kb_ready, line, print_valid, lamp, busy, echo;
   int          num_errors, tests_run, pcount;
   logic [7:0]  eq[$];

   abs_answerback #(.BIT_CYCLES(BC)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
      .prdata_out(prdata), .pslverr_out(pslverr), .rx_valid_in(rx_valid),
      .rx_char_in(rx_char), .here_is_in(here_is), .ext_trip_in(ext_trip),
      .np_on_in(np_on), .np_off_in(np_off), .kb_valid_in(kb_valid),
      .kb_char_in(kb_char), .kb_ready_out(kb_ready), .line_out(line),
      .print_valid_out(print_valid), .print_char_out(print_char),
      .np_lamp_out(lamp), .ab_busy_out(busy));
   abs_far_station #(.BIT_CYCLES(BC)) i_far (.clk_in(clk_in),
      .rst_in(rst_in), .line_in(line), .echo_in(echo),
      .rx_valid_out(rx_valid), .rx_char_out(rx_char));

   // clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // count printed characters
   always @(posedge clk_in) begin
      if (print_valid === 1'b1) begin
         pcount++;
         plast = print_char;
      end
   end
   task check_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task check_seq;
      int n;
      n = i_far.got.size();
      check_word(n, eq.size());
      for (int i = 0; i < n && i < eq.size(); i++)
         check_word(i_far.got[i], eq[i]);
      i_far.got.delete();
      eq.delete();
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         num_errors++;
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one-cycle pulse: 0 local request, 1 trip, 2 inhibit on, 3 off
   task pulse(input int k);
      @(posedge clk_in);
      case (k)
         0: here_is <= 1'b1;
         1: ext_trip <= 1'b1;
         2: np_on <= 1'b1;
         default: np_off <= 1'b1;
      endcase
      @(posedge clk_in);
      {here_is, ext_trip, np_on, np_off} <= 4'h0;
      repeat (3) @(posedge clk_in);
   endtask
   task trig(input int k);
      case (k)
         0: i_far.send(8'h05);
         1: pulse(0);
         default: pulse(1);
      endcase
   endtask
   task wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge clk_in);
      do begin
         apb(1'b0, `ABS_STAT_OFS, 32'h0);
         n++;
      end while (rdv[0] !== 1'b0 && n < 2000);
      check_word(rdv[0], 1'b0);
      repeat (33 * BC) @(posedge clk_in);
   endtask
   task expect_rows(input int first, input int last);
      for (int r = first + 1; r <= last; r++)
         eq.push_back(8'h40 + 8'(r - first));
   endtask
   task kb_send(input logic [7:0] c);
      int n;
      n = 0;
      @(posedge clk_in);
      kb_valid <= 1'b1;
      kb_char <= c;
      do begin
         @(posedge clk_in);
         n++;
      end while (kb_ready !== 1'b1 && n < 100);
      if (kb_ready !== 1'b1)
         num_errors++;
      kb_valid <= 1'b0;
      kb_char <= ~c;
   endtask
   task t_reset;
      apb(1'b0, `ABS_CTRL_OFS, 32'h0);
      check_word(rdv, {16'h0, `ABS_CALL_RST, 8'h00});
      check_word(line, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check_word({erv, rdv}, {1'b1, 32'h0});
   endtask
   // same message in every segment of len rows; last segment takes the rest
   task t_load(input logic last_sup, input int len);
      int s;
      for (int r = 0; r < `ABS_ROWS; r++) begin
         s = r / len;
         if (s > `ABS_ROWS / len - 1)
            s = `ABS_ROWS / len - 1;
         apb(1'b1, `ABS_MADDR_OFS, r);
         apb(1'b1, `ABS_MDATA_OFS, {23'h0, last_sup && r == 20,
                                   8'h40 + 8'(r - len * s)});
      end
   endtask
   task t_single;
      apb(1'b1, `ABS_CTRL_OFS, 32'h0500);
      trig(0);
      repeat (300) @(posedge clk_in);
      check_word(busy, 1'b1);
      trig(1);
      kb_send(8'h31);
      kb_send(8'h32);
      repeat (3) @(posedge clk_in);
      check_word(kb_ready, 1'b0);
      wait_idle;
      expect_rows(0, 20);
      eq.push_back(8'h31);
      eq.push_back(8'h32);
      check_seq;
   endtask
   task t_multi;
      t_load(1'b0, 10);
      apb(1'b1, `ABS_CTRL_OFS, 32'h0501);
      for (int k = 0; k < 2; k++) begin
         trig(k + 1);
         wait_idle;
         expect_rows(k * 10, k ? 20 : 9);
         check_seq;
      end
      t_load(1'b0, 7);
      apb(1'b1, `ABS_CTRL_OFS, 32'h0502);
      for (int k = 0; k < 3; k++) begin
         trig(k);
         wait_idle;
         expect_rows(k * 7, k * 7 + 6);
         check_seq;
      end
      apb(1'b1, `ABS_CTRL_OFS, 32'h0500);
   endtask
   task t_echo;
      echo <= 1'b1;
      kb_send(8'h05);
      repeat (150 * BC) @(posedge clk_in);
      echo <= 1'b0;
      wait_idle;
      eq.push_back(8'h05);
      check_seq;
   endtask
   task t_print;
      int pc;
      pc = pcount;
      pulse(2);
      check_word(lamp, 1'b1);
      i_far.send(8'h05);
      repeat (300) @(posedge clk_in);
      check_word(pcount, pc);
      check_seq;
      pulse(3);
      check_word(lamp, 1'b0);
      i_far.send(8'h41);
      repeat (3) @(posedge clk_in);
      check_word(pcount, pc + 1);
      check_word(plast, 8'h41);
      apb(1'b1, `ABS_CTRL_OFS, 32'h0504);
      repeat (3) @(posedge clk_in);
      check_word(lamp, 1'b1);
      apb(1'b1, `ABS_CTRL_OFS, 32'h0500);
   endtask
   task t_block;
      trig(1);
      wait_idle;
      expect_rows(0, 19);
      check_seq;
      apb(1'b0, `ABS_STAT_OFS, 32'h0);
      check_word(rdv[1], 1'b1);
      trig(1);
      wait_idle;
      check_seq;
      i_far.send(8'h41);
      trig(2);
      wait_idle;
      expect_rows(0, 19);
      check_seq;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (90000) @(posedge clk_in);
      num_errors++;
      give_verdict;
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {here_is, ext_trip, np_on, np_off, kb_valid, kb_char, echo} = '0;
      {num_errors, tests_run, pcount, plast} = '0;
      rst_in = 1'b1;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_reset;
      t_load(1'b0, 21);
      t_single;
      t_multi;
      t_echo;
      t_print;
      t_load(1'b1, 21);
      t_block;
      give_verdict;
   end
endmodule
